// file: rtl/pmc_map.svh
// constants for the power management capability register bank
// assumes: included by its bare name from the rtl folder
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// register byte offsets
`define PMC_OFF_CAP 12'h0C0
`define PMC_OFF_LOCK 12'h0E0
`define PMC_OFF_STAT 12'h0E4

// capability word fields
`define PMC_ID_LSB 0
`define PMC_ID_VAL 8'h01
`define PMC_NXT_LSB 8
`define PMC_NXT_RST 8'h00
`define PMC_VER_LSB 16
`define PMC_VER_VAL 3'h3
`define PMC_SPECIAL_INIT_REQUIRED_BIT 21
`define PMC_SPECIAL_INIT_REQUIRED_RST 1'h0
`define PMC_WAKE_LSB 27
`define PMC_WAKE_RST 5'h19

// unlock register field
`define PMC_UNLOCK_BIT 0
`define PMC_UNLOCK_RST 1'h0

// status register fields
`define PMC_ST_MASK_LSB 0
`define PMC_ST_COLD_BIT 5
`define PMC_ST_FWD_LSB 8
`define PMC_ST_BLK_LSB 16
`define PMC_CNT_RST 8'h00

// index of the unpowered state in the wake-event field
`define PMC_COLD_IDX 4

`endif

// file: rtl/pmc_pkg.sv
// types shared by the power management capability block
// assumes: compiled before every other design file
package pmc_pkg;
  typedef logic [31:0] pmc_word_t;
  typedef logic [11:0] pmc_addr_t;
  typedef logic [4:0] pmc_wake_t;
  typedef enum logic [0:0] {PMC_ST_IDLE, PMC_ST_RESP} pmc_apb_st_t;
endpackage

// file: rtl/pmc_req_if.sv
// request/answer carrier between the apb front end and the register bank
// assumes: both ends on the same clock
`timescale 1ns/1ps
interface pmc_req_if;
  import pmc_pkg::*;
  logic acc;
  logic commit;
  logic write;
  pmc_addr_t addr;
  pmc_word_t wdata;
  logic [3:0] strb;
  pmc_word_t rdata;
  logic err;
  modport front (output acc, commit, write, addr, wdata, strb, input rdata, err);
  modport bank (input acc, commit, write, addr, wdata, strb, output rdata, err);
endinterface

// file: rtl/pmc_apb_slave.sv
// apb slave front end: one wait state, registered answer
// assumes: apb master on clock_in, bank decodes address combinationally
`timescale 1ns/1ps
module pmc_apb_slave (
  input wire logic clock_in,          // system clock
  input wire logic sys_rst_in,        // async reset, high
  input wire pmc_pkg::pmc_addr_t paddr_in, // byte address
  input wire logic psel_in,           // select
  input wire logic penable_in,        // access phase
  input wire logic pwrite_in,         // direction
  input wire pmc_pkg::pmc_word_t pwdata_in, // write data
  input wire logic [3:0] pstrb_in,    // byte lanes
  output logic pready_out,            // answer
  output pmc_pkg::pmc_word_t prdata_out, // read data
  output logic pslverr_out,           // unmapped address
  pmc_req_if.front req                // to register bank
);
  import pmc_pkg::*;

  pmc_apb_st_t st_reg, st_next;
  pmc_word_t rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic ready_reg, ready_next;

  assign req.acc = psel_in && penable_in && (st_reg == PMC_ST_IDLE);
  assign req.commit = psel_in && penable_in && (st_reg == PMC_ST_RESP);
  assign req.write = pwrite_in;
  assign req.addr = paddr_in;
  assign req.wdata = pwdata_in;
  assign req.strb = pstrb_in;

  always_comb begin
    st_next = st_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    unique case (st_reg)
      PMC_ST_IDLE: begin
        if (req.acc) begin
          st_next = PMC_ST_RESP;
          rdata_next = pwrite_in ? 32'h0000_0000 : req.rdata;
          err_next = req.err;
        end
      end
      PMC_ST_RESP: begin
        // the write lands on this edge, while pready is seen high
        st_next = PMC_ST_IDLE;
        err_next = 1'b0;
      end
    endcase
    ready_next = (st_next == PMC_ST_RESP);
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= PMC_ST_IDLE;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      ready_reg <= ready_next;
    end
  end

  assign pready_out = ready_reg;
  assign prdata_out = rdata_reg;
  assign pslverr_out = err_reg;

  AST_PREADY_ONE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    pready_out |=> !pready_out)
    else $error("pready held for more than one cycle");
endmodule

// file: rtl/pmc_wake_gate.sv
// wake message forwarding gate, fixed to the reset support set
// assumes: wake_req_in and power_state_in come from logic on clock_in,
// cold_in is an asynchronous pin
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_wake_gate #(
  parameter pmc_pkg::pmc_wake_t FIXED_MASK = `PMC_WAKE_RST
) (
  input wire logic clock_in,          // system clock
  input wire logic sys_rst_in,        // async reset, high
  input wire logic wake_req_in,       // wake event to forward, pulse
  input wire logic [1:0] power_state_in, // current powered state
  input wire logic cold_in,           // unpowered indication, async pin
  output logic wake_fwd_out,          // forwarded wake message, pulse
  output logic wake_blk_out,          // event dropped, pulse
  output logic cold_out               // synchronised unpowered level
);
  import pmc_pkg::*;

  logic cold_meta_reg, cold_sync_reg;
  logic fwd_reg, fwd_next, blk_reg, blk_next;

  // the mask is a parameter, so advertised writes cannot reach it
  always_comb begin
    fwd_next = 1'b0;
    blk_next = 1'b0;
    if (wake_req_in) begin
      if (!cold_sync_reg && FIXED_MASK[power_state_in]) begin // RULE10
        fwd_next = 1'b1;
      end else begin
        blk_next = 1'b1; // RULE9
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cold_meta_reg <= 1'b0;
      cold_sync_reg <= 1'b0;
      fwd_reg <= 1'b0;
      blk_reg <= 1'b0;
    end else begin
      cold_meta_reg <= cold_in;
      cold_sync_reg <= cold_meta_reg;
      fwd_reg <= fwd_next;
      blk_reg <= blk_next;
    end
  end

  assign wake_fwd_out = fwd_reg;
  assign wake_blk_out = blk_reg;
  assign cold_out = cold_sync_reg;

  AST_COLD_BLOCK: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE9
    cold_sync_reg && wake_req_in |=> !wake_fwd_out && wake_blk_out)
    else $error("wake forwarded while unpowered");
  AST_FIXED_MASK: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE10
    wake_req_in && !cold_sync_reg |=> wake_fwd_out == FIXED_MASK[$past(power_state_in)])
    else $error("wake forwarding differs from fixed support set");
endmodule

// file: rtl/pmc_cap_bank.sv
// power management capability word with apb access, unlock and status
// assumes: apb master on clock_in, initialization loader on clock_in,
// wake requests and power state from logic on clock_in
//
// Overview of operation
// RULE1: lowest byte reads one, writes ignored
// RULE2: bits 15:8 hold loadable next-capability offset
// RULE3: bits 18:16 read constant version three
// RULE4: bit 19 wake-clock flag always reads zero
// RULE5: bit 21 loadable flag, resets to zero
// RULE6: bits 24:22 aux current read zero
// RULE7: bits 25 and 26 read zero
// RULE8: wake-support field 31:27 resets to 11001
// RULE9: no wake forwarding while unpowered
// RULE10: field writes change readback, not forwarding
// RULE11: read-only and reserved bit 20 discard writes
// RULE12: loadable fields change only via init/unlocked path
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_cap_bank #(
  parameter logic [7:0] NXT_RST = `PMC_NXT_RST
) (
  input wire logic clock_in,          // system clock, 125 MHz
  input wire logic sys_rst_in,        // async reset, high
  input wire pmc_pkg::pmc_addr_t paddr_in, // apb byte address
  input wire logic psel_in,           // apb select
  input wire logic penable_in,        // apb access phase
  input wire logic pwrite_in,         // apb direction
  input wire pmc_pkg::pmc_word_t pwdata_in, // apb write data
  input wire logic [3:0] pstrb_in,    // apb byte lanes
  output logic pready_out,            // apb answer
  output pmc_pkg::pmc_word_t prdata_out, // apb read data
  output logic pslverr_out,           // apb error
  input wire logic init_load_in,      // initialization load, pulse
  input wire pmc_pkg::pmc_word_t init_wdata_in, // initialization word
  input wire logic wake_req_in,       // wake event to forward, pulse
  input wire logic [1:0] power_state_in, // current powered state
  input wire logic cold_in,           // unpowered indication, async pin
  output logic wake_fwd_out,          // forwarded wake message, pulse
  output pmc_pkg::pmc_word_t cap_word_out // advertised capability word
);
  import pmc_pkg::*;

  pmc_req_if req ();

  logic wake_blk;
  logic cold_sync;

  pmc_apb_slave u_apb (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .paddr_in(paddr_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in),
    .pready_out(pready_out),
    .prdata_out(prdata_out),
    .pslverr_out(pslverr_out),
    .req(req.front)
  );

  pmc_wake_gate #(
    .FIXED_MASK(`PMC_WAKE_RST)
  ) u_wake (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .wake_req_in(wake_req_in),
    .power_state_in(power_state_in),
    .cold_in(cold_in),
    .wake_fwd_out(wake_fwd_out),
    .wake_blk_out(wake_blk),
    .cold_out(cold_sync)
  );

  // address decode
  logic hit_cap, hit_lock, hit_stat;
  assign hit_cap = (req.addr == `PMC_OFF_CAP);
  assign hit_lock = (req.addr == `PMC_OFF_LOCK);
  assign hit_stat = (req.addr == `PMC_OFF_STAT);
  assign req.err = !(hit_cap || hit_lock || hit_stat);

  logic wr_cap, wr_lock;
  assign wr_cap = req.commit && req.write && hit_cap;
  assign wr_lock = req.commit && req.write && hit_lock;

  // loadable state
  logic [7:0] nxt_reg, nxt_next;
  logic special_init_required_reg, special_init_required_next;
  pmc_wake_t wake_reg, wake_next;
  logic unlock_reg, unlock_next;

  // loader wins over a capability bus write in the same cycle; the loader carries the
  // whole loadable set, the bus write only its strobed lanes, and is dropped
  always_comb begin
    nxt_next = nxt_reg;
    special_init_required_next = special_init_required_reg;
    wake_next = wake_reg;
    unlock_next = unlock_reg;
    if (wr_lock && req.strb[0]) begin
      unlock_next = req.wdata[`PMC_UNLOCK_BIT];
    end
    if (init_load_in) begin // RULE12
      nxt_next = init_wdata_in[`PMC_NXT_LSB +: 8]; // RULE2
      special_init_required_next = init_wdata_in[`PMC_SPECIAL_INIT_REQUIRED_BIT]; // RULE5
      wake_next = init_wdata_in[`PMC_WAKE_LSB +: 5]; // RULE10
    end else if (wr_cap && unlock_reg) begin // RULE12
      if (req.strb[1]) begin
        nxt_next = req.wdata[`PMC_NXT_LSB +: 8]; // RULE2
      end
      if (req.strb[2]) begin
        special_init_required_next = req.wdata[`PMC_SPECIAL_INIT_REQUIRED_BIT]; // RULE5
      end
      if (req.strb[3]) begin
        wake_next = req.wdata[`PMC_WAKE_LSB +: 5]; // RULE10
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nxt_reg <= NXT_RST;
      special_init_required_reg <= `PMC_SPECIAL_INIT_REQUIRED_RST; // RULE5
      wake_reg <= `PMC_WAKE_RST; // RULE8
      unlock_reg <= `PMC_UNLOCK_RST;
    end else begin
      nxt_reg <= nxt_next;
      special_init_required_reg <= special_init_required_next;
      wake_reg <= wake_next;
      unlock_reg <= unlock_next;
    end
  end

  // capability word: constant fields built here, stored by the cap_out_reg copy and, on a read, by the apb rdata_reg
  pmc_word_t cap_word;
  always_comb begin
    cap_word = 32'h0000_0000; // RULE4 RULE6 RULE7 RULE11
    cap_word[`PMC_ID_LSB +: 8] = `PMC_ID_VAL; // RULE1
    cap_word[`PMC_NXT_LSB +: 8] = nxt_reg; // RULE2
    cap_word[`PMC_VER_LSB +: 3] = `PMC_VER_VAL; // RULE3
    cap_word[`PMC_SPECIAL_INIT_REQUIRED_BIT] = special_init_required_reg; // RULE5
    cap_word[`PMC_WAKE_LSB +: 5] = wake_reg; // RULE8
  end

  // status counters saturate so software sees "many" rather than a wrap
  logic [7:0] fwd_cnt_reg, fwd_cnt_next;
  logic [7:0] blk_cnt_reg, blk_cnt_next;
  always_comb begin
    fwd_cnt_next = fwd_cnt_reg;
    blk_cnt_next = blk_cnt_reg;
    if (wake_fwd_out && fwd_cnt_reg != 8'hFF) begin
      fwd_cnt_next = fwd_cnt_reg + 8'h01;
    end
    if (wake_blk && blk_cnt_reg != 8'hFF) begin
      blk_cnt_next = blk_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fwd_cnt_reg <= `PMC_CNT_RST;
      blk_cnt_reg <= `PMC_CNT_RST;
    end else begin
      fwd_cnt_reg <= fwd_cnt_next;
      blk_cnt_reg <= blk_cnt_next;
    end
  end

  pmc_word_t stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`PMC_ST_MASK_LSB +: 5] = `PMC_WAKE_RST;
    stat_word[`PMC_ST_COLD_BIT] = cold_sync;
    stat_word[`PMC_ST_FWD_LSB +: 8] = fwd_cnt_reg;
    stat_word[`PMC_ST_BLK_LSB +: 8] = blk_cnt_reg;
  end

  // read mux
  always_comb begin
    req.rdata = 32'h0000_0000;
    if (hit_cap) begin
      req.rdata = cap_word;
    end else if (hit_lock) begin
      req.rdata[`PMC_UNLOCK_BIT] = unlock_reg;
    end else if (hit_stat) begin
      req.rdata = stat_word;
    end
  end

  pmc_word_t cap_out_reg;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_out_reg <= 32'h0000_0000;
    end else begin
      cap_out_reg <= cap_word;
    end
  end
  assign cap_word_out = cap_out_reg;

  // checks
  AST_CAP_ID: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE1
    req.acc && !req.write && hit_cap |=> prdata_out[7:0] == 8'h01 && pready_out)
    else $error("capability id not one on read");
  AST_VERSION: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE3
    req.acc && !req.write && hit_cap |=> prdata_out[18:16] == 3'h3)
    else $error("version code not three");
  AST_CLK_FLAG: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE4
    req.acc && !req.write && hit_cap |=> prdata_out[19] == 1'b0)
    else $error("wake clock flag not zero");
  AST_AUX_ZERO: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE6
    ##1 cap_word_out[24:22] == 3'h0)
    else $error("aux current field not zero");
  AST_LOWPWR_ZERO: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE7
    wr_cap && unlock_reg |=> ##1 cap_word_out[26:25] == 2'h0)
    else $error("light sleep support bits not zero after write");
  AST_RSVD_ZERO: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE11
    wr_cap && req.wdata[20] |=> ##1 cap_word_out[20] == 1'b0 && cap_word_out[7:0] == 8'h01)
    else $error("read-only bits took a write");
  AST_SPECIAL_INIT_REQUIRED_LOAD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE5
    wr_cap && unlock_reg && req.strb[2] && !init_load_in
    |=> special_init_required_reg == $past(req.wdata[21]))
    else $error("device specific flag not loaded");
  AST_NXT_LOAD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE2
    init_load_in |=> ##1 cap_word_out[15:8] == $past(init_wdata_in[15:8], 2))
    else $error("next pointer not taken from loader");
  AST_LOCKED: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE12
    wr_cap && !unlock_reg && !init_load_in
    |=> $stable(nxt_reg) && $stable(special_init_required_reg) && $stable(wake_reg))
    else $error("locked write changed a loadable field");
  AST_WAKE_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE8
    !init_load_in && !wr_cap |=> $stable(wake_reg))
    else $error("wake support field changed with no write");
  // compared against the constant, not wake_reg, so a rewired gate shows up
  localparam pmc_wake_t FWD_SET = `PMC_WAKE_RST;
  AST_WAKE_FIXED: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE10
    wake_req_in && !cold_sync && wake_reg != FWD_SET
    |=> wake_fwd_out == FWD_SET[$past(power_state_in)])
    else $error("forwarding set follows advertised field");
  AST_STAT_SET: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE10
    stat_word[4:0] == FWD_SET)
    else $error("status shows a wrong forwarding set");

  // read-back of the remaining capability fields and the unlock field, one cycle after the access edge
  AST_NXT_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE2
    req.acc && !req.write && hit_cap |=> prdata_out[15:8] == $past(nxt_reg))
    else $error("next pointer read back wrong");
  AST_SPECIAL_INIT_REQUIRED_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE5
    req.acc && !req.write && hit_cap |=> prdata_out[21] == $past(special_init_required_reg))
    else $error("init flag read back wrong");
  AST_AUX_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE6
    req.acc && !req.write && hit_cap |=> prdata_out[24:22] == 3'h0)
    else $error("aux current read back nonzero");
  AST_LOWPWR_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE7
    req.acc && !req.write && hit_cap |=> prdata_out[26:25] == 2'h0)
    else $error("light sleep support read back nonzero");
  AST_RSVD_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE11
    req.acc && !req.write && hit_cap |=> prdata_out[20] == 1'b0)
    else $error("reserved bit read back nonzero");
  AST_WAKE_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE8
    req.acc && !req.write && hit_cap |=> prdata_out[31:27] == $past(wake_reg))
    else $error("wake support field read back wrong");
  AST_CAP_NOERR: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE1
    req.acc && hit_cap |=> !pslverr_out)
    else $error("capability access flagged as error");
  AST_UNMAPPED: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE11
    req.acc && req.err |=> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_LOCK_READ: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE12
    req.acc && !req.write && hit_lock
    |=> prdata_out[31:1] == 31'h0 && prdata_out[0] == $past(unlock_reg))
    else $error("unlock bit read back wrong");

  // loader and lock paths
  AST_LOAD_NXT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE2
    init_load_in |=> nxt_reg == $past(init_wdata_in[15:8]))
    else $error("loader did not set next pointer");
  AST_LOAD_SPECIAL_INIT_REQUIRED: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE5
    init_load_in |=> special_init_required_reg == $past(init_wdata_in[21]))
    else $error("loader did not set init flag");
  AST_LOAD_WAKE: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE12
    init_load_in |=> wake_reg == $past(init_wdata_in[31:27]))
    else $error("loader did not set wake support field");
  AST_NXT_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE2
    !init_load_in && !wr_cap |=> $stable(nxt_reg))
    else $error("next pointer changed with no write");
  AST_SPECIAL_INIT_REQUIRED_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE5
    !init_load_in && !wr_cap |=> $stable(special_init_required_reg))
    else $error("init flag changed with no write");
  AST_LANE_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE12
    wr_cap && unlock_reg && !req.strb[3] && !init_load_in
    |=> $stable(wake_reg))
    else $error("wake field written with its lane off");
  AST_UNLOCK_WR: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE12
    wr_lock && req.strb[0] |=> unlock_reg == $past(req.wdata[0]))
    else $error("unlock bit not written");
  AST_LOCK_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE12
    !(wr_lock && req.strb[0]) |=> $stable(unlock_reg))
    else $error("unlock bit changed with no write");

  // status counters
  AST_FWD_COUNT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE10
    wake_fwd_out && fwd_cnt_reg != 8'hFF |=> fwd_cnt_reg == $past(fwd_cnt_reg) + 8'h01)
    else $error("forwarded count did not step");
  AST_BLK_COUNT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE9
    wake_blk && blk_cnt_reg != 8'hFF |=> blk_cnt_reg == $past(blk_cnt_reg) + 8'h01)
    else $error("blocked count did not step");
  AST_FWD_SAT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE10
    fwd_cnt_reg == 8'hFF |=> fwd_cnt_reg == 8'hFF)
    else $error("forwarded count wrapped");
  AST_BLK_SAT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE9
    blk_cnt_reg == 8'hFF |=> blk_cnt_reg == 8'hFF)
    else $error("blocked count wrapped");
endmodule

// file: dv/pmc_cap_bank_tb_top.sv
// self-checking bench for the power management capability register bank
// assumes: design package, interface and modules compiled before this file
`timescale 1ns/1ps
module pmc_cap_bank_tb_top;
  import pmc_pkg::*;
  typedef struct {pmc_addr_t a; pmc_word_t d; logic e; logic w;} pmc_exp_t;
  localparam logic [7:0] NXT = 8'h5C;
  localparam pmc_word_t FIXED = 32'h00030001;
  localparam pmc_word_t LOADM = 32'hF820FF00;
  localparam pmc_word_t RSTW = 32'hC8035C01;
  localparam pmc_addr_t CAP = 12'h0C0;
  localparam pmc_addr_t UNL = 12'h0E0;
  localparam pmc_addr_t STS = 12'h0E4;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  pmc_addr_t paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  pmc_word_t pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready_out;
  pmc_word_t prdata_out;
  logic pslverr_out;
  logic init_load = 1'b0;
  pmc_word_t init_wdata = 32'h0;
  logic wake_req = 1'b0;
  logic [1:0] pstate = 2'h0;
  logic cold_in = 1'b0;
  logic wake_fwd_out;
  pmc_word_t cap_word_out;
  pmc_exp_t expq[$];
  logic wakeq[$];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  pmc_word_t seed = 32'h8917;

  pmc_cap_bank #(.NXT_RST(NXT)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .init_load_in(init_load), .init_wdata_in(init_wdata), .wake_req_in(wake_req),
    .power_state_in(pstate), .cold_in(cold_in), .wake_fwd_out(wake_fwd_out),
    .cap_word_out(cap_word_out)
  );

  always #4 clock_in = ~clock_in;

  function automatic pmc_word_t lfsr(input pmc_word_t v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic tally_and_finish();
    if (wakeq.size() != 0) bad("missing wake pulse");
    if (expq.size() != 0) bad("missing bus answer");
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // note the expectation first, then hold the request until ready is seen
  task automatic apb(input logic w, input pmc_addr_t a, input pmc_word_t d,
                     input logic [3:0] s, input pmc_word_t ed, input logic ee);
    int n;
    n = 0;
    expq.push_back('{a, ed, ee, w});
    @(posedge clock_in);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge clock_in);
    penable <= 1'b1;
    // pready is read at the rising edge itself, before the design updates it
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) bad("no ready");
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input pmc_addr_t a, input pmc_word_t d, input logic [3:0] s,
                    input logic ee);
    apb(1'b1, a, d, s, 32'h0, ee);
  endtask

  task automatic rd(input pmc_addr_t a, input pmc_word_t ed, input logic ee);
    apb(1'b0, a, 32'h0, 4'h0, ed, ee);
  endtask

  task automatic wake(input logic [1:0] st, input logic fwd);
    if (fwd) wakeq.push_back(1'b1);
    @(posedge clock_in);
    {wake_req, pstate} <= {1'b1, st};
    @(posedge clock_in);
    wake_req <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask

  // registered outputs are settled by the falling edge
  always @(negedge clock_in) begin
    pmc_exp_t ex;
    if (pready_out === 1'b1 && psel && penable) begin
      if (expq.size() == 0) begin
        bad("answer with no request");
      end else begin
        ex = expq.pop_front();
        checks_done++;
        if (pslverr_out !== ex.e) bad("error flag wrong");
        if (!ex.w) begin
          if (prdata_out !== ex.d) bad("read data wrong");
          if (ex.a == CAP && cap_word_out !== ex.d) bad("advertised word wrong");
          if (ex.a == CAP && (prdata_out & ~LOADM) !== FIXED) bad("fixed field wrong");
        end
      end
    end
    if (wake_fwd_out === 1'b1) begin
      checks_done++;
      if (wakeq.size() == 0) bad("unexpected wake pulse");
      else void'(wakeq.pop_front());
    end
  end

  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad("timeout");
      tally_and_finish();
    end
  end

  initial begin
    pmc_word_t cur;
    pmc_word_t r;
    pmc_word_t lm;
    logic [3:0] s;
    cur = RSTW;
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(CAP, cur, 1'b0);
    wr(CAP, 32'hFFFFFFFF, 4'hF, 1'b0);
    rd(CAP, cur, 1'b0);
    wr(STS, 32'hFFFFFFFF, 4'hF, 1'b0);
    wr(12'h100, 32'hFFFFFFFF, 4'hF, 1'b1);
    rd(12'h100, 32'h0, 1'b1);
    wr(UNL, 32'h1, 4'hF, 1'b0);
    rd(UNL, 32'h1, 1'b0);
    wr(CAP, 32'hFFFFFFFF, 4'hF, 1'b0);
    cur = 32'hF823FF01;
    rd(CAP, cur, 1'b0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      s = seed[3:0];
      lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & LOADM;
      cur = (cur & ~lm) | (r & lm);
      wr(CAP, r, s, 1'b0);
      rd(CAP, cur, 1'b0);
    end
    wr(UNL, 32'h0, 4'hF, 1'b0);
    // loader clears the advertised wake set, forwarding must not follow it
    seed = lfsr(seed);
    r = seed & 32'h07FFFFFF;
    cur = (cur & ~LOADM) | (r & LOADM);
    @(posedge clock_in);
    {init_load, init_wdata} <= {1'b1, r};
    @(posedge clock_in);
    init_load <= 1'b0;
    rd(CAP, cur, 1'b0);
    for (int p = 0; p < 4; p++) wake(p[1:0], p == 0 || p == 3);
    cold_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    for (int p = 0; p < 4; p++) wake(p[1:0], 1'b0);
    rd(STS, 32'h00060239, 1'b0);
    cold_in <= 1'b0;
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(CAP, RSTW, 1'b0);
    rd(UNL, 32'h0, 1'b0);
    repeat (4) @(posedge clock_in);
    tally_and_finish();
  end
endmodule
